// ### rtl/core_pkg.sv
// shared constants and types for the core register file and status flags
package core_pkg;

  // ****************************************
  // data space map
  // ****************************************
  localparam int REG_COUNT = 32;
  localparam logic [7:0] REGFILE_LAST = 8'h1F;
  localparam logic [7:0] IO_BASE = 8'h20;
  localparam logic [7:0] IO_LAST = 8'h5F;
  localparam logic [7:0] EXT_BASE = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;
  localparam logic [5:0] STATUS_IO_INDEX = 6'h3F;
  localparam logic [7:0] STATUS_ADDR = 8'h5F;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ****************************************
  // status flag positions
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;

  // ****************************************
  // data read source held between request and answer
  // ****************************************
  localparam logic [1:0] KIND_REG = 2'h0;
  localparam logic [1:0] KIND_STATUS = 2'h1;
  localparam logic [1:0] KIND_PERIPH = 2'h2;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADC = 4'h1,
    OP_SUB = 4'h2,
    OP_SBC = 4'h3,
    OP_AND = 4'h4,
    OP_OR = 4'h5,
    OP_XOR = 4'h6,
    OP_MOV = 4'h7,
    OP_ADDW = 4'h8,
    OP_SUBW = 4'h9,
    OP_MOVW = 4'hA
  } alu_op_t;

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] cells;
    logic [7:0] dr_data;
  } mem_state_t;

  typedef struct packed {
    logic [7:0] status;
    logic [15:0] result;
    logic rd_pending;
    logic [1:0] rd_kind;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] periph_addr;
    logic [7:0] periph_wdata;
    logic periph_wr;
    logic periph_rd;
  } core_state_t;

endpackage

// ### rtl/regfile_if.sv
// port bundle between the core logic and the working register array
`timescale 1ns/1ps
interface regfile_if;
  logic [4:0] rd_a_addr;
  logic [4:0] rd_b_addr;
  logic [7:0] rd_a_data;
  logic [7:0] rd_b_data;
  logic [4:0] wr_addr;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wr_data;
  logic [4:0] dr_addr;
  logic [7:0] dr_data;

  modport store (
    input rd_a_addr, rd_b_addr, wr_addr, wr_lo, wr_hi, wr_data, dr_addr,
    output rd_a_data, rd_b_data, dr_data
  );
  modport user (
    output rd_a_addr, rd_b_addr, wr_addr, wr_lo, wr_hi, wr_data, dr_addr,
    input rd_a_data, rd_b_data, dr_data
  );
endinterface // regfile_if

// ### rtl/regfile_mem.sv
// 32 x 8 working register array with operand, write and data-space ports
`timescale 1ns/1ps
module regfile_mem (
  input logic clock,
  input logic rstn,
  regfile_if.store rf
);
  import core_pkg::*;

  mem_state_t st_reg;
  mem_state_t st_next;

  // ****************************************
  // operand ports
  // ****************************************
  // operands are read without a register so the alu finishes in one cycle
  assign rf.rd_a_data = st_reg.cells[rf.rd_a_addr];
  assign rf.rd_b_data = st_reg.cells[rf.rd_b_addr];
  assign rf.dr_data = st_reg.dr_data;

  // ****************************************
  // write port and registered data-space read
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.dr_data = st_reg.cells[rf.dr_addr];
    // (RULE_02) byte or pair write
    if (rf.wr_lo) begin
      st_next.cells[rf.wr_addr] = rf.wr_data[7:0];
    end
    // (RULE_03) high byte at the odd address
    if (rf.wr_hi) begin
      st_next.cells[{rf.wr_addr[4:1], 1'b1}] = rf.wr_data[15:8];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  AST_PAIR_WRITE: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
    rf.wr_lo && rf.wr_hi && !rf.wr_addr[0] |=>
      st_reg.cells[{$past(rf.wr_addr[4:1]), 1'b1}] == $past(rf.wr_data[15:8]) &&
      st_reg.cells[$past(rf.wr_addr)] == $past(rf.wr_data[7:0]))
    else $error("pair write did not land in both bytes");

endmodule // regfile_mem

// ### rtl/core_register_file_and_flags.sv
// core working registers, pointer pairs, status flags and data-space decode
//
// Contract
// (RULE_01) Thirty-two 8-bit working registers also answer at data addresses 0x00 to 0x1F.
// (RULE_02) One cycle allows 8r+8w, two 8r+8w, two 8r+16w, or 16r+16w register access.
// (RULE_03) Registers 0x1A/0x1B, 0x1C/0x1D, 0x1E/0x1F pair as pointers, low byte at the lower.
// (RULE_04) Sixteen-bit arithmetic on a register pair completes in one cycle.
// (RULE_05) Both alu operands are read and the result written back in the same cycle.
// (RULE_06) Every flag-setting alu operation updates the status flags from its result.
// (RULE_07) Status bit 1 is set when the result is zero and cleared otherwise.
// (RULE_08) Status bit 2 copies the most significant bit of the result.
// (RULE_09) Status bit 4 equals the negative flag xor the overflow flag.
// (RULE_10) Status bit 5 is set on a carry out of the low nibble of a byte operation.
// (RULE_11) The status register is neither saved on interrupt entry nor restored on return.
// (RULE_12) Sixty-four i/o locations are reached by i/o index or at data 0x20 to 0x5F.
// (RULE_13) Data 0x60 to 0xFF is extended i/o, reachable only by data-space access.
// (RULE_14) Accepting an interrupt clears the global interrupt enable, status bit 7.
// (RULE_15) The interrupt return instruction sets the global interrupt enable again.
// (RULE_16) Bit 0 records carry or borrow out of the top bit, bit 3 two's-complement overflow.
`timescale 1ns/1ps
module core_register_file_and_flags (
  input logic clock,
  input logic rstn,
  input logic op_valid,
  input core_pkg::alu_op_t op,
  input logic [4:0] dst_sel,
  input logic [4:0] src_sel,
  input logic [7:0] imm,
  input logic use_imm,
  input logic irq_accept,
  input logic interrupt_return_instruction,
  input logic [7:0] data_addr,
  input logic io_space,
  input logic data_wr,
  input logic data_rd,
  input logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic data_rvalid,
  output logic [7:0] periph_addr,
  output logic periph_wr,
  output logic periph_rd,
  output logic [7:0] periph_wdata,
  input logic [7:0] periph_rdata,
  output logic [15:0] result,
  output logic [7:0] processor_status_flags
);
  import core_pkg::*;

  core_state_t st_reg;
  core_state_t st_next;
  regfile_if rf ();

  logic [7:0] mapped;
  logic wide;
  logic alu_write;
  logic flag_op;
  logic [4:0] base;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [15:0] pair;
  logic [15:0] res;
  logic [8:0] sum9;
  logic [16:0] sum17;
  logic [7:0] flags;
  logic cin;
  logic is_periph;

  regfile_mem u_mem (
    .clock(clock),
    .rstn(rstn),
    .rf(rf)
  );

  // ****************************************
  // registered outputs
  // ****************************************
  assign data_rdata = st_reg.rdata;
  assign data_rvalid = st_reg.rvalid;
  assign periph_addr = st_reg.periph_addr;
  assign periph_wr = st_reg.periph_wr;
  assign periph_rd = st_reg.periph_rd;
  assign periph_wdata = st_reg.periph_wdata;
  assign result = st_reg.result;
  assign processor_status_flags = st_reg.status;

  // ****************************************
  // operand fetch, alu, write-back and address decode
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.periph_wr = 1'b0;
    st_next.periph_rd = 1'b0;
    st_next.rvalid = 1'b0;
    // (RULE_12) i/o index lands 0x20 above its number
    mapped = io_space ? (IO_BASE + {2'b00, data_addr[5:0]}) : data_addr;
    wide = (op == OP_ADDW) || (op == OP_SUBW) || (op == OP_MOVW);
    base = (op == OP_MOVW) ? src_sel : dst_sel;
    // (RULE_02) two byte reads or one pair read
    rf.rd_a_addr = wide ? {base[4:1], 1'b0} : dst_sel;
    rf.rd_b_addr = wide ? {base[4:1], 1'b1} : src_sel;
    opa = rf.rd_a_data;
    opb = use_imm ? imm : rf.rd_b_data;
    // (RULE_03) lower address is the low byte
    pair = {rf.rd_b_data, rf.rd_a_data};
    cin = st_reg.status[FLAG_C];
    flags = st_reg.status;
    res = 16'h0000;
    sum9 = 9'h000;
    sum17 = 17'h0_0000;
    alu_write = 1'b1;
    flag_op = 1'b1;
    // (RULE_16) carry, borrow and overflow per class
    case (op)
      OP_ADD, OP_ADC: begin
        sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, (op == OP_ADC) & cin};
        res = {8'h00, sum9[7:0]};
        flags[FLAG_C] = sum9[8];
        flags[FLAG_V] = (opa[7] & opb[7] & ~res[7]) | (~opa[7] & ~opb[7] & res[7]);
        // (RULE_10) nibble carry
        flags[FLAG_H] = (opa[3] & opb[3]) | (opb[3] & ~res[3]) | (~res[3] & opa[3]);
      end
      OP_SUB, OP_SBC: begin
        sum9 = {1'b0, opa} - {1'b0, opb} - {8'h00, (op == OP_SBC) & cin};
        res = {8'h00, sum9[7:0]};
        flags[FLAG_C] = sum9[8];
        flags[FLAG_V] = (opa[7] & ~opb[7] & ~res[7]) | (~opa[7] & opb[7] & res[7]);
        // (RULE_10) nibble borrow
        flags[FLAG_H] = (~opa[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~opa[3]);
      end
      OP_AND, OP_OR, OP_XOR: begin
        if (op == OP_AND) begin
          res = {8'h00, opa & opb};
        end else if (op == OP_OR) begin
          res = {8'h00, opa | opb};
        end else begin
          res = {8'h00, opa ^ opb};
        end
        flags[FLAG_V] = 1'b0;
      end
      OP_MOV: begin
        res = {8'h00, opb};
        flag_op = 1'b0;
      end
      // (RULE_04) single-cycle pointer arithmetic
      OP_ADDW: begin
        sum17 = {1'b0, pair} + {9'h000, opb};
        res = sum17[15:0];
        flags[FLAG_C] = sum17[16];
        flags[FLAG_V] = ~pair[15] & res[15];
      end
      OP_SUBW: begin
        sum17 = {1'b0, pair} - {9'h000, opb};
        res = sum17[15:0];
        flags[FLAG_C] = sum17[16];
        flags[FLAG_V] = pair[15] & ~res[15];
      end
      OP_MOVW: begin
        res = pair;
        flag_op = 1'b0;
      end
      default: begin
        alu_write = 1'b0;
        flag_op = 1'b0;
      end
    endcase
    // (RULE_07) zero over the full result width
    flags[FLAG_Z] = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
    // (RULE_08) top bit of the result
    flags[FLAG_N] = wide ? res[15] : res[7];
    // (RULE_09) sign from negative and overflow
    flags[FLAG_S] = flags[FLAG_N] ^ flags[FLAG_V];

    // (RULE_05) same-cycle write-back, the alu owns the write port
    alu_write = alu_write && op_valid;
    rf.wr_addr = wide ? {dst_sel[4:1], 1'b0} : dst_sel;
    rf.wr_lo = alu_write;
    rf.wr_hi = alu_write && wide;
    rf.wr_data = res;
    if (alu_write) begin
      st_next.result = res;
    end
    // (RULE_01) data-space store into a working register
    if (!alu_write && data_wr && mapped <= REGFILE_LAST) begin
      rf.wr_addr = mapped[4:0];
      rf.wr_lo = 1'b1;
      rf.wr_hi = 1'b0;
      rf.wr_data = {8'h00, data_wdata};
    end
    rf.dr_addr = mapped[4:0];

    // status register: software store, then alu flags, then interrupt enable
    if (data_wr && mapped == STATUS_ADDR) begin
      st_next.status = data_wdata;
    end
    // (RULE_06) flags follow the last flag-setting alu result
    if (op_valid && flag_op) begin
      st_next.status[5:0] = flags[5:0];
    end
    // (RULE_11) nothing is stacked here, the isr must save the flags itself
    // (RULE_14) accept wins over a return in the same cycle
    if (irq_accept) begin
      st_next.status[FLAG_I] = 1'b0;
    // (RULE_15) return re-enables interrupts
    end else if (interrupt_return_instruction) begin
      st_next.status[FLAG_I] = 1'b1;
    end

    // (RULE_13) everything above the registers except the status byte goes out
    is_periph = (mapped >= IO_BASE) && (mapped != STATUS_ADDR);
    if ((data_wr || data_rd) && is_periph) begin
      st_next.periph_addr = mapped;
      st_next.periph_wdata = data_wdata;
      st_next.periph_wr = data_wr;
      st_next.periph_rd = data_rd;
    end
    // reads answer two edges after the request, whatever the region
    st_next.rd_pending = data_rd;
    if (mapped <= REGFILE_LAST) begin
      st_next.rd_kind = KIND_REG;
    end else if (mapped == STATUS_ADDR) begin
      st_next.rd_kind = KIND_STATUS;
    end else begin
      st_next.rd_kind = KIND_PERIPH;
    end
    if (st_reg.rd_pending) begin
      st_next.rvalid = 1'b1;
      case (st_reg.rd_kind)
        KIND_REG: st_next.rdata = rf.dr_data;
        KIND_STATUS: st_next.rdata = st_reg.status;
        default: st_next.rdata = periph_rdata;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.status <= STATUS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_ADD_WRITEBACK: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
    op_valid && op == OP_ADD |=> result[7:0] == 8'($past(opa) + $past(opb)))
    else $error("add result not written back in one cycle");
  AST_ZERO_FLAG: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
    op_valid && op == OP_AND && !irq_accept |=> processor_status_flags[1] == (result[7:0] == 8'h00))
    else $error("zero flag does not match result");
  AST_NEG_FLAG: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
    op_valid && (op == OP_ADD || op == OP_SUB) |=> processor_status_flags[2] == result[7])
    else $error("negative flag does not match result msb");
  AST_SIGN_FLAG: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
    op_valid && op == OP_SUB |=>
      processor_status_flags[4] == (processor_status_flags[2] ^ processor_status_flags[3]))
    else $error("sign flag is not n xor v");
  AST_HALF_CARRY: assert property (@(posedge clock) disable iff (!rstn) // RULE_10
    op_valid && op == OP_ADD |=>
      processor_status_flags[5] == (({1'b0, $past(opa[3:0])} + {1'b0, $past(opb[3:0])}) > 5'h0F))
    else $error("half carry wrong");
  AST_PAIR_ADD: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
    op_valid && op == OP_ADDW |=> result == 16'($past(pair) + {8'h00, $past(opb)}))
    else $error("pair add wrong");
  AST_IRQ_CLEAR: assert property (@(posedge clock) disable iff (!rstn) // RULE_14
    irq_accept |=> !processor_status_flags[7])
    else $error("interrupt accept left enable set");
  AST_RETURN_SET: assert property (@(posedge clock) disable iff (!rstn) // RULE_15
    interrupt_return_instruction && !irq_accept |=> processor_status_flags[7])
    else $error("return did not set interrupt enable");
  AST_IO_MAP: assert property (@(posedge clock) disable iff (!rstn) // RULE_12
    data_wr && io_space && data_addr[5:0] != STATUS_IO_INDEX |=>
      periph_wr && periph_addr == 8'(IO_BASE + {2'b00, $past(data_addr[5:0])}))
    else $error("i/o index not mapped above 0x20");
  AST_EXT_READ: assert property (@(posedge clock) disable iff (!rstn) // RULE_13
    data_rd && !io_space && data_addr >= EXT_BASE |=> periph_rd ##1 data_rvalid)
    else $error("extended read not forwarded and answered");

endmodule // core_register_file_and_flags

// ### testbench/periph_model.sv
// peripheral-side model answering mapped i/o and extended data accesses
`timescale 1ns/1ps
module periph_model (
  input wire logic clock,
  input wire logic [7:0] periph_addr,
  input wire logic periph_wr,
  input wire logic periph_rd,
  input wire logic [7:0] periph_wdata,
  output logic [7:0] periph_rdata
);
  logic [7:0] store_reg [256];
  logic [7:0] noise_reg = 8'h00;
  // ****************
  // storage and idle pattern
  // ****************
  // mapped locations
  always @(posedge clock) begin
    noise_reg <= noise_reg + 8'h5B;
    if (periph_wr) begin
      store_reg[periph_addr] <= periph_wdata;
    end
  end
  // answer only while a load is open; otherwise a moving pattern so stale data never passes
  assign periph_rdata = periph_rd ? store_reg[periph_addr] : noise_reg;
endmodule // periph_model

// ### testbench/core_register_file_and_flags_bench.sv
// self-checking bench for the core register file and status flags
`timescale 1ns/1ps
module core_register_file_and_flags_bench;
  import core_pkg::*;
  typedef struct packed {
    alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] pre;
    logic [7:0] res;
    logic [7:0] flg;
  } row_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic op_valid = 1'b0;
  alu_op_t op = OP_ADD;
  logic [4:0] dst_sel = 5'h00;
  logic [4:0] src_sel = 5'h00;
  logic [7:0] imm = 8'h00;
  logic use_imm = 1'b0;
  logic irq_accept = 1'b0;
  logic interrupt_return_instruction = 1'b0;
  logic [7:0] data_addr = 8'h00;
  logic io_space = 1'b0;
  logic data_wr = 1'b0;
  logic data_rd = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] data_rdata;
  logic data_rvalid;
  logic [7:0] periph_addr;
  logic periph_wr;
  logic periph_rd;
  logic [7:0] periph_wdata;
  logic [7:0] periph_rdata;
  logic [15:0] result;
  logic [7:0] processor_status_flags;
  logic [7:0] rd_val;
  int miscompares = 0;
  int cmp_count = 0;
  // operands, preset status, expected result and full status after the op
  row_t rows [11] = '{
    '{OP_ADD, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h20},
    '{OP_ADD, 8'h80, 8'h80, 8'h00, 8'h00, 8'h1B},
    '{OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h2C},
    '{OP_ADC, 8'h01, 8'h01, 8'h01, 8'h03, 8'h00},
    '{OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h35},
    '{OP_SUB, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h38},
    '{OP_SBC, 8'h05, 8'h03, 8'h01, 8'h01, 8'h00},
    '{OP_AND, 8'hF0, 8'h0F, 8'h21, 8'h00, 8'h23},
    '{OP_OR, 8'h80, 8'h01, 8'h40, 8'h81, 8'h54},
    '{OP_XOR, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h02},
    '{OP_MOV, 8'h00, 8'h55, 8'h3F, 8'h55, 8'h3F}
  };

  core_register_file_and_flags uut (.clock, .rstn, .op_valid, .op, .dst_sel, .src_sel, .imm,
    .use_imm, .irq_accept, .interrupt_return_instruction, .data_addr, .io_space, .data_wr,
    .data_rd, .data_wdata, .data_rdata, .data_rvalid, .periph_addr, .periph_wr, .periph_rd,
    .periph_wdata, .periph_rdata, .result, .processor_status_flags);
  periph_model pm (.clock, .periph_addr, .periph_wr, .periph_rd, .periph_wdata,
    .periph_rdata);

  // ****************
  // clock, checking and closing
  // ****************
  // 100 MHz core clock
  always #5 clock = ~clock;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************
  // request tasks, all driven on the falling edge
  // ****************
  task automatic dwr(input logic [7:0] a, input logic io, input logic [7:0] d);
    @(negedge clock);
    data_addr = a;
    io_space = io;
    data_wdata = d;
    data_wr = 1'b1;
    @(negedge clock);
    data_wr = 1'b0;
  endtask

  // load; the answer strobe is awaited with a bounded count and its latency is checked
  task automatic drd(input logic [7:0] a, input logic io, output logic [7:0] d);
    int n;
    @(negedge clock);
    data_addr = a;
    io_space = io;
    data_rd = 1'b1;
    @(negedge clock);
    data_rd = 1'b0;
    n = 0;
    while (data_rvalid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    chk("load latency", n[15:0], 16'h0001);
    d = data_rdata;
  endtask

  task automatic alu(input alu_op_t o, input logic [4:0] d, input logic [4:0] s,
                     input logic [7:0] i, input logic u);
    @(negedge clock);
    op = o;
    dst_sel = d;
    src_sel = s;
    imm = i;
    use_imm = u;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
  endtask

  task automatic evt(input logic a, input logic r);
    @(negedge clock);
    irq_accept = a;
    interrupt_return_instruction = r;
    @(negedge clock);
    irq_accept = 1'b0;
    interrupt_return_instruction = 1'b0;
  endtask

  // ****************
  // main sequence
  // ****************
  // reset values first, then the table, pairs, mapped space, interrupt enable and a second reset
  initial begin
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    chk("status after reset", processor_status_flags, STATUS_RESET);
    drd(8'h07, 1'b0, rd_val);
    chk("reg after reset", rd_val, 8'h00);
    foreach (rows[k]) begin
      dwr(8'h02, 1'b0, rows[k].a);
      dwr(8'h03, 1'b0, rows[k].b);
      dwr(8'h3F, 1'b1, rows[k].pre);
      alu(rows[k].op, 5'h02, 5'h03, 8'h00, 1'b0);
      chk("result", result, {8'h00, rows[k].res});
      chk("flags", processor_status_flags, rows[k].flg);
      drd(8'h02, 1'b0, rd_val);
      chk("dest reg", rd_val, rows[k].res);
    end
    alu(OP_ADD, 5'h02, 5'h00, 8'h05, 1'b1);
    chk("imm add", result, 16'h005A);
    dwr(8'h1A, 1'b0, 8'hFF);
    dwr(8'h1B, 1'b0, 8'h12);
    alu(OP_ADDW, 5'h1A, 5'h00, 8'h01, 1'b1);
    chk("word add", result, 16'h1300);
    alu(OP_SUBW, 5'h1C, 5'h00, 8'h01, 1'b1);
    chk("word sub", result, 16'hFFFF);
    chk("word sub c z n", {13'h0000, processor_status_flags[2:0]}, 16'h0005);
    drd(8'h1D, 1'b0, rd_val);
    chk("pair high after sub", rd_val, 8'hFF);
    alu(OP_MOVW, 5'h1E, 5'h1A, 8'h00, 1'b0);
    drd(8'h1E, 1'b0, rd_val);
    chk("pair low", rd_val, 8'h00);
    drd(8'h1F, 1'b0, rd_val);
    chk("pair high", rd_val, 8'h13);
    dwr(8'h05, 1'b1, 8'hA7);
    chk("io store addr", periph_addr, 8'h25);
    chk("io store pulse", periph_wr, 1'b1);
    chk("io store data", periph_wdata, 8'hA7);
    dwr(8'h80, 1'b0, 8'h3C);
    chk("ext store addr", periph_addr, 8'h80);
    drd(8'h25, 1'b0, rd_val);
    chk("io load via data", rd_val, 8'hA7);
    drd(8'h80, 1'b0, rd_val);
    chk("ext load", rd_val, 8'h3C);
    dwr(8'h5F, 1'b0, 8'h83);
    evt(1'b1, 1'b0);
    chk("accept", processor_status_flags, 8'h03);
    evt(1'b0, 1'b1);
    chk("return", processor_status_flags, 8'h83);
    evt(1'b1, 1'b1);
    chk("accept beats return", processor_status_flags, 8'h03);
    // status byte answers at its i/o index without going out to the peripherals
    drd(8'h3F, 1'b1, rd_val);
    chk("status via io index", rd_val, 8'h03);
    // an undecoded op code must leave result, flags and registers alone
    alu(alu_op_t'(4'hB), 5'h02, 5'h03, 8'h00, 1'b0);
    chk("undefined op result", result, 16'h1300);
    chk("undefined op flags", processor_status_flags, 8'h03);
    drd(8'h02, 1'b0, rd_val);
    chk("undefined op dest", rd_val, 8'h5A);
    @(negedge clock);
    rstn = 1'b0;
    @(negedge clock);
    chk("status in reset", processor_status_flags, STATUS_RESET);
    rstn = 1'b1;
    // the mid-run reset must also have cleared the register array
    drd(8'h1F, 1'b0, rd_val);
    chk("reg cleared by reset", rd_val, 8'h00);
    stop_test();
  end

  // a hang is cut short well beyond the roughly 180 cycles the run needs
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
endmodule // core_register_file_and_flags_bench
